// ===== rtl/acbc_pkg.sv
// Package for the auxiliary control and boot configuration block.
package acbc_pkg;
  localparam logic [7:0] ACBC_AUX_ADDR = 8'hA2;
  localparam logic [7:0] ACBC_PTR_LO_ADDR = 8'h82;
  localparam logic [7:0] ACBC_PTR_HI_ADDR = 8'h83;
  localparam logic [7:0] ACBC_AUX_RESET = 8'h00;
  localparam int ACBC_BIT_KEYPAD = 7;
  localparam int ACBC_BIT_BO_OFF = 6;
  localparam int ACBC_BIT_BO_IRQ = 5;
  localparam int ACBC_BIT_LPCM = 4;
  localparam int ACBC_BIT_SOFT_RESET_BIT = 3;
  localparam int ACBC_BIT_ZERO = 2;
  localparam int ACBC_BIT_RSVD = 1;
  localparam int ACBC_BIT_PSEL = 0;
  localparam logic [15:0] ACBC_SIG0_ADDR = 16'hFC30;
  localparam logic [15:0] ACBC_SIG1_ADDR = 16'hFC31;
  localparam logic [15:0] ACBC_SIG2_ADDR = 16'hFC60;
  localparam logic [15:0] ACBC_CUST_BASE = 16'hFCE0;
  localparam logic [10:0] ACBC_CUST_TAG = 11'h7E7;
  localparam logic [15:0] ACBC_CFG_ADDR = 16'hFD00;
  localparam logic [7:0] ACBC_CFG_BLANK = 8'hFF;
  localparam int ACBC_CFG_WDOG = 7;
  localparam int ACBC_CFG_RPIN = 6;
  localparam int ACBC_CFG_PORT_RESET_LEVEL = 5;
  localparam int ACBC_CFG_BOV = 4;
  localparam int ACBC_CFG_CLOCK_RATE_SELECT = 3;
  localparam logic [2:0] ACBC_OSC_EXT = 3'h7;
  localparam logic [2:0] ACBC_OSC_RC6 = 3'h3;
  localparam logic [2:0] ACBC_OSC_LF = 3'h5;
  localparam logic [2:0] ACBC_OSC_MF = 3'h1;
  localparam logic [2:0] ACBC_OSC_HF = 3'h0;

  typedef enum logic [2:0] {
    ACBC_PTR_NONE,
    ACBC_PTR_INC,
    ACBC_PTR_LOAD16,
    ACBC_PTR_WR_LO,
    ACBC_PTR_WR_HI
  } acbc_ptr_op_e;

  typedef struct packed {
    logic watchdog_reset_en;
    logic reset_pin_off;
    logic port_reset_level;
    logic brownout_level_select;
    logic clock_div2;
    logic [2:0] osc_type_select;
    logic osc_external;
    logic osc_rc_6mhz;
    logic osc_reserved;
  } acbc_cfg_s;
endpackage

// ===== rtl/acbc_aux_control.sv
// Auxiliary control register, dual data pointers and boot configuration view.
`timescale 1ns/1ps
// Function
// - Writing aux_control with bit 3 set resets the whole processor.
// - Two data pointers exist; pointer_select chooses the visible one.
// - All pointer instructions and byte accesses use the selected pointer.
// - Bit 2 of aux_control always reads zero.
// - Keypad flag sets on a low keypad pin; only software clears it.
// - Brownout off bit disables brownout detection entirely.
// - Brownout irq select turns brownout reset into an interrupt.
// - Low-power code bit: software sets; only power-on or brownout clears.
// - Signature bytes readable by code read at FC30h, FC31h, FC60h.
// - Customer area FCE0h-FCFFh readable as data, not executable.
// - Config byte read-only via external data move at FD00h, blank FFh.
// - Config settings take effect at power-up, fixed afterwards.
// - Config bit 7 zero: watchdog cannot reset, interrupt still allowed.
// - Config bit 6 one: reset pin becomes input only.
// - Config bit 5 sets port reset level high or low.
// - Config bit 4 selects brownout threshold 2.5V or 3.8V.
// - Config bit 3 zero divides CPU and peripheral clocks by two.
// - Oscillator field 111 external clock; 011 internal 6 MHz RC.
module acbc_aux_control
  import acbc_pkg::*;
#(
  parameter logic [7:0] SIG_BYTE0 = 8'h11,
  parameter logic [7:0] SIG_BYTE1 = 8'h22,
  parameter logic [7:0] SIG_BYTE2 = 8'h33,
  parameter int CUST_BYTES = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic por_bo_reset,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire acbc_ptr_op_e ptr_op,
  input wire logic [15:0] ptr_load_val,
  output logic [15:0] data_pointer,
  input wire logic code_rd,
  input wire logic [15:0] code_addr,
  output logic code_hit,
  output logic [7:0] code_rdata,
  input wire logic xdata_rd,
  input wire logic [15:0] xdata_addr,
  output logic xdata_hit,
  output logic [7:0] xdata_rdata,
  input wire logic [7:0] boot_config_one,
  input wire logic [3:0] keypad_pins_n,
  input wire logic [3:0] keypad_enable,
  input wire logic brownout_raw,
  input wire logic watchdog_expired,
  input wire logic reset_input_pin,
  output logic soft_reset_bit,
  output logic pointer_select,
  output logic keypad_flag,
  output logic brownout_off,
  output logic brownout_irq_select,
  output logic low_power_code_mem,
  output logic brownout_reset_req,
  output logic brownout_irq_req,
  output logic watchdog_reset_req,
  output logic reset_pin_reset_req,
  output logic reset_input_level,
  output acbc_cfg_s cfg,
  output logic [7:0] cust_wdata_unused
);
  // The customer area is indexed with five address bits, so only 32 bytes fit.
  if (CUST_BYTES != 32) begin : g_cust_bytes_check
    $error("CUST_BYTES must be 32");
  end

  logic soft_reset_bit_r;
  logic keypad_flag_r;
  logic bo_off_r;
  logic bo_irq_r;
  logic lpcm_r;
  logic rsvd_r;
  logic psel_r;
  logic [7:0] aux_rd;
  logic [15:0] ptr0_r;
  logic [15:0] ptr1_r;
  logic [7:0] cfg_r;
  logic cfg_loaded_r;
  logic [3:0] kp_s1_r;
  logic [3:0] kp_s2_r;
  logic [3:0] kp_s3_r;
  logic [2:0] rp_sync_r;
  logic rp_r;
  logic [2:0] bo_sync_r;
  logic bo_r;
  logic [7:0] cust_mem [0:31];
  logic aux_wr;
  logic kp_event;
  logic [15:0] sel_ptr;
  logic [15:0] sel_ptr_nxt;

  assign aux_wr = sfr_wr && (sfr_addr == ACBC_AUX_ADDR);
  assign cust_wdata_unused = 8'h00;

  // Customer area is never written here; every byte reads all ones, as in a blank EPROM.
  initial begin
    for (int i = 0; i < 32; i++) begin
      cust_mem[i] = 8'hFF;
    end
  end

  // keypad pin sync.
  // Three stages; a low is only seen once the second and third agree.
  always_ff @(posedge clk) begin
    kp_s1_r <= keypad_pins_n;
    kp_s2_r <= kp_s1_r;
    kp_s3_r <= kp_s2_r;
  end
  assign kp_event = |(keypad_enable & ~kp_s2_r & ~kp_s3_r);

  always_ff @(posedge clk) begin
    rp_sync_r <= {rp_sync_r[1:0], reset_input_pin};
    bo_sync_r <= {bo_sync_r[1:0], brownout_raw};
    if (rp_sync_r[1] == rp_sync_r[2]) begin
      rp_r <= rp_sync_r[2];
    end
    if (bo_sync_r[1] == bo_sync_r[2]) begin
      bo_r <= bo_sync_r[2];
    end
  end

  // soft reset control.
  // The write is held for one cycle as a pulse; the system reset logic
  // feeds it back into rst_n, which then clears this register too.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      soft_reset_bit_r <= ACBC_AUX_RESET[ACBC_BIT_SOFT_RESET_BIT];
    end else begin
      soft_reset_bit_r <= aux_wr && sfr_wdata[ACBC_BIT_SOFT_RESET_BIT];
    end
  end

  // keypad flag set wins.
  // A clear landing in the same cycle as a key press loses, so a racing
  // software write can never drop a press.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      keypad_flag_r <= ACBC_AUX_RESET[ACBC_BIT_KEYPAD];
    end else if (kp_event) begin
      keypad_flag_r <= 1'b1;
    end else if (aux_wr) begin
      keypad_flag_r <= sfr_wdata[ACBC_BIT_KEYPAD];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bo_off_r <= ACBC_AUX_RESET[ACBC_BIT_BO_OFF];
    end else if (aux_wr) begin
      bo_off_r <= sfr_wdata[ACBC_BIT_BO_OFF];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bo_irq_r <= ACBC_AUX_RESET[ACBC_BIT_BO_IRQ];
    end else if (aux_wr) begin
      bo_irq_r <= sfr_wdata[ACBC_BIT_BO_IRQ];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      psel_r <= ACBC_AUX_RESET[ACBC_BIT_PSEL];
    end else if (aux_wr) begin
      psel_r <= sfr_wdata[ACBC_BIT_PSEL];
    end
  end

  // Reserved bit one is stored so that a read returns what was written.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rsvd_r <= ACBC_AUX_RESET[ACBC_BIT_RSVD];
    end else if (aux_wr) begin
      rsvd_r <= sfr_wdata[ACBC_BIT_RSVD];
    end
  end

  // sticky low-power bit.
  // A soft or watchdog reset leaves it alone; only por_bo_reset clears it.
  always_ff @(posedge clk) begin
    if (por_bo_reset) begin
      lpcm_r <= ACBC_AUX_RESET[ACBC_BIT_LPCM];
    end else if (aux_wr && sfr_wdata[ACBC_BIT_LPCM]) begin
      lpcm_r <= 1'b1;
    end
  end

  always_comb begin
    aux_rd = 8'h00;
    aux_rd[ACBC_BIT_KEYPAD] = keypad_flag_r;
    aux_rd[ACBC_BIT_BO_OFF] = bo_off_r;
    aux_rd[ACBC_BIT_BO_IRQ] = bo_irq_r;
    aux_rd[ACBC_BIT_LPCM] = lpcm_r;
    aux_rd[ACBC_BIT_SOFT_RESET_BIT] = soft_reset_bit_r;
    aux_rd[ACBC_BIT_ZERO] = 1'b0;
    aux_rd[ACBC_BIT_RSVD] = rsvd_r;
    aux_rd[ACBC_BIT_PSEL] = psel_r;
  end

  assign sel_ptr = psel_r ? ptr1_r : ptr0_r;

  always_comb begin
    sel_ptr_nxt = sel_ptr;
    unique case (ptr_op)
      ACBC_PTR_NONE: sel_ptr_nxt = sel_ptr;
      ACBC_PTR_INC: sel_ptr_nxt = sel_ptr + 16'h0001;
      ACBC_PTR_LOAD16: sel_ptr_nxt = ptr_load_val;
      ACBC_PTR_WR_LO: sel_ptr_nxt = {sel_ptr[15:8], ptr_load_val[7:0]};
      ACBC_PTR_WR_HI: sel_ptr_nxt = {ptr_load_val[7:0], sel_ptr[7:0]};
      default: sel_ptr_nxt = sel_ptr;
    endcase
    if (sfr_wr && sfr_addr == ACBC_PTR_LO_ADDR) begin
      sel_ptr_nxt = {sel_ptr[15:8], sfr_wdata};
    end else if (sfr_wr && sfr_addr == ACBC_PTR_HI_ADDR) begin
      sel_ptr_nxt = {sfr_wdata, sel_ptr[7:0]};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ptr0_r <= 16'h0000;
      ptr1_r <= 16'h0000;
    end else if (psel_r) begin
      ptr1_r <= sel_ptr_nxt;
    end else begin
      ptr0_r <= sel_ptr_nxt;
    end
  end
  assign data_pointer = sel_ptr;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sfr_rdata <= 8'h00;
    end else begin
      unique case (sfr_addr)
        ACBC_AUX_ADDR: sfr_rdata <= aux_rd;
        ACBC_PTR_LO_ADDR: sfr_rdata <= sel_ptr[7:0];
        ACBC_PTR_HI_ADDR: sfr_rdata <= sel_ptr[15:8];
        default: sfr_rdata <= 8'h00;
      endcase
    end
  end

  // config capture once.
  // Latched at the first clock after power-up reset and then frozen, so a
  // soft reset cannot pick up a changed byte.
  always_ff @(posedge clk) begin
    if (por_bo_reset) begin
      cfg_loaded_r <= 1'b0;
      cfg_r <= ACBC_CFG_BLANK;
    end else if (!cfg_loaded_r) begin
      cfg_loaded_r <= 1'b1;
      cfg_r <= boot_config_one;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      code_hit <= 1'b0;
      code_rdata <= 8'h00;
    end else begin
      code_hit <= 1'b0;
      code_rdata <= 8'h00;
      if (code_rd) begin
        if (code_addr == ACBC_SIG0_ADDR) begin
          code_hit <= 1'b1;
          code_rdata <= SIG_BYTE0;
        end else if (code_addr == ACBC_SIG1_ADDR) begin
          code_hit <= 1'b1;
          code_rdata <= SIG_BYTE1;
        end else if (code_addr == ACBC_SIG2_ADDR) begin
          code_hit <= 1'b1;
          code_rdata <= SIG_BYTE2;
        end else if (code_addr[15:5] == ACBC_CUST_TAG) begin
          code_hit <= 1'b1;
          code_rdata <= cust_mem[code_addr[4:0]];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      xdata_hit <= 1'b0;
      xdata_rdata <= 8'h00;
    end else begin
      xdata_hit <= xdata_rd && (xdata_addr == ACBC_CFG_ADDR);
      xdata_rdata <= (xdata_rd && xdata_addr == ACBC_CFG_ADDR) ? cfg_r : 8'h00;
    end
  end

  assign cfg.watchdog_reset_en = cfg_r[ACBC_CFG_WDOG];
  assign watchdog_reset_req = watchdog_expired && cfg_r[ACBC_CFG_WDOG];
  assign cfg.reset_pin_off = cfg_r[ACBC_CFG_RPIN];
  assign reset_pin_reset_req = !cfg_r[ACBC_CFG_RPIN] && !rp_r;
  assign reset_input_level = rp_r;
  assign cfg.port_reset_level = cfg_r[ACBC_CFG_PORT_RESET_LEVEL];
  assign cfg.brownout_level_select = cfg_r[ACBC_CFG_BOV];
  assign cfg.clock_div2 = !cfg_r[ACBC_CFG_CLOCK_RATE_SELECT];
  assign cfg.osc_type_select = cfg_r[2:0];
  assign cfg.osc_external = cfg_r[2:0] == ACBC_OSC_EXT;
  assign cfg.osc_rc_6mhz = cfg_r[2:0] == ACBC_OSC_RC6;
  assign cfg.osc_reserved = !(cfg_r[2:0] == ACBC_OSC_EXT || cfg_r[2:0] == ACBC_OSC_RC6 ||
    cfg_r[2:0] == ACBC_OSC_LF || cfg_r[2:0] == ACBC_OSC_MF || cfg_r[2:0] == ACBC_OSC_HF);

  assign brownout_reset_req = bo_r && !bo_off_r && !bo_irq_r;
  assign brownout_irq_req = bo_r && !bo_off_r && bo_irq_r;

  assign soft_reset_bit = soft_reset_bit_r;
  assign pointer_select = psel_r;
  assign keypad_flag = keypad_flag_r;
  assign brownout_off = bo_off_r;
  assign brownout_irq_select = bo_irq_r;
  assign low_power_code_mem = lpcm_r;
endmodule

// ===== tb/acbc_asserts.sv
// Checker for the auxiliary control and boot configuration block.
`timescale 1ns/1ps
module acbc_asserts
  import acbc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic por_bo_reset,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic code_rd,
  input wire logic [15:0] code_addr,
  input wire logic code_hit,
  input wire logic soft_reset_bit,
  input wire logic pointer_select,
  input wire logic keypad_flag,
  input wire logic brownout_off,
  input wire logic brownout_irq_select,
  input wire logic low_power_code_mem,
  input wire logic brownout_reset_req,
  input wire logic watchdog_reset_req,
  input wire acbc_cfg_s cfg
);
  logic aux_wr;
  logic sig_hit;
  assign aux_wr = sfr_wr && sfr_addr == ACBC_AUX_ADDR;
  assign sig_hit = code_addr inside {ACBC_SIG0_ADDR, ACBC_SIG1_ADDR, ACBC_SIG2_ADDR};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // The capture edge itself may still move cfg, so three quiet edges are awaited.
  sequence s_por_done;
    !por_bo_reset [*3];
  endsequence
  sequence s_code_req;
    code_rd && (sig_hit || code_addr[15:5] == ACBC_CUST_TAG);
  endsequence
  chk_soft_reset_pulse: assert property (aux_wr && sfr_wdata[3] |=> soft_reset_bit)
    else $error("soft reset pulse missing");
  chk_select_follows: assert property (
    aux_wr |=> pointer_select == $past(sfr_wdata[ACBC_BIT_PSEL]))
    else $error("pointer select not updated");
  chk_bit2_zero: assert property (sfr_addr == ACBC_AUX_ADDR |=> !sfr_rdata[2])
    else $error("aux bit 2 read as one");
  chk_keypad_sticky: assert property (
    keypad_flag && !(aux_wr && !sfr_wdata[7]) |=> keypad_flag)
    else $error("keypad flag cleared by hardware");
  chk_lpcm_sticky: assert property (
    low_power_code_mem && !por_bo_reset |=> low_power_code_mem)
    else $error("low power code bit cleared");
  chk_bo_off_quiet: assert property (brownout_off |-> !brownout_reset_req)
    else $error("brownout reset while detection off");
  chk_bo_irq_mode: assert property (brownout_irq_select |-> !brownout_reset_req)
    else $error("brownout reset in interrupt mode");
  chk_cfg_frozen: assert property (s_por_done |-> $stable(cfg))
    else $error("config changed after power up");
  chk_wdog_masked: assert property (!cfg.watchdog_reset_en |-> !watchdog_reset_req)
    else $error("watchdog reset while disabled");
  chk_code_hit: assert property (s_code_req |=> code_hit)
    else $error("code read of info area missed");
endmodule
bind acbc_aux_control acbc_asserts u_chk (.clk(clk), .rst_n(rst_n),
  .por_bo_reset(por_bo_reset), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
  .sfr_rdata(sfr_rdata), .code_rd(code_rd), .code_addr(code_addr), .code_hit(code_hit),
  .soft_reset_bit(soft_reset_bit), .pointer_select(pointer_select),
  .keypad_flag(keypad_flag), .brownout_off(brownout_off),
  .brownout_irq_select(brownout_irq_select), .low_power_code_mem(low_power_code_mem),
  .brownout_reset_req(brownout_reset_req), .watchdog_reset_req(watchdog_reset_req), .cfg(cfg));

// ===== tb/tb_top.sv
// Testbench for the auxiliary control and boot configuration block.
`timescale 1ns/1ps
module tb_top
  import acbc_pkg::*;
();
  logic clk = 0, rst_n = 0, por_bo_reset = 1, sfr_wr = 0, code_rd = 0, xdata_rd = 0, h;
  logic brownout_raw = 1, watchdog_expired = 1, reset_input_pin = 0;
  logic [7:0] sfr_addr = 0, sfr_wdata = 0, boot_config_one = 8'hFF, d, e, c;
  logic [7:0] sfr_rdata, code_rdata, xdata_rdata, cust_wdata_unused;
  logic [15:0] ptr_load_val = 0, code_addr = 0, xdata_addr = 0, data_pointer, p0;
  logic [3:0] keypad_pins_n = 4'hF, keypad_enable = 4'h0;
  logic code_hit, xdata_hit, soft_reset_bit, pointer_select, keypad_flag, brownout_off;
  logic brownout_irq_select, low_power_code_mem, brownout_reset_req, brownout_irq_req;
  logic watchdog_reset_req, reset_pin_reset_req, reset_input_level;
  acbc_ptr_op_e ptr_op = ACBC_PTR_NONE;
  acbc_cfg_s cfg;
  logic [2:0] osc [5] = '{ACBC_OSC_EXT, ACBC_OSC_RC6, ACBC_OSC_LF, ACBC_OSC_MF, ACBC_OSC_HF};
  logic [23:0] rd_tab [5] = '{{ACBC_SIG0_ADDR, 8'h11}, {ACBC_SIG1_ADDR, 8'h22},
    {ACBC_SIG2_ADDR, 8'h33}, {16'hFCE0, 8'hFF}, {16'hFCFF, 8'hFF}};
  logic [31:0] seed = 32'h0000005E;
  int num_errors = 0;
  int tests_run = 0;
  always #20 clk = ~clk;
  acbc_aux_control dut (.clk(clk), .rst_n(rst_n), .por_bo_reset(por_bo_reset),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .ptr_op(ptr_op), .ptr_load_val(ptr_load_val), .data_pointer(data_pointer),
    .code_rd(code_rd), .code_addr(code_addr), .code_hit(code_hit), .code_rdata(code_rdata),
    .xdata_rd(xdata_rd), .xdata_addr(xdata_addr), .xdata_hit(xdata_hit),
    .xdata_rdata(xdata_rdata), .boot_config_one(boot_config_one),
    .keypad_pins_n(keypad_pins_n), .keypad_enable(keypad_enable), .brownout_raw(brownout_raw),
    .watchdog_expired(watchdog_expired), .reset_input_pin(reset_input_pin),
    .soft_reset_bit(soft_reset_bit), .pointer_select(pointer_select),
    .keypad_flag(keypad_flag), .brownout_off(brownout_off),
    .brownout_irq_select(brownout_irq_select), .low_power_code_mem(low_power_code_mem),
    .brownout_reset_req(brownout_reset_req), .brownout_irq_req(brownout_irq_req),
    .watchdog_reset_req(watchdog_reset_req), .reset_pin_reset_req(reset_pin_reset_req),
    .reset_input_level(reset_input_level), .cfg(cfg), .cust_wdata_unused());
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  // Bit 4 can only be set by a write, never cleared by one.
  function automatic logic [7:0] aux_exp(input logic [7:0] p, input logic [7:0] w);
    return (w & 8'h71) | (p & 8'h10);
  endfunction
  function automatic acbc_cfg_s cfg_exp(input logic [7:0] b);
    return {b[7:4], ~b[3], b[2:0], b[2:0] == ACBC_OSC_EXT, b[2:0] == ACBC_OSC_RC6,
      b[2:0] inside {3'h2, 3'h4, 3'h6}};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    if (num_errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic do_reset(input logic por, input logic [7:0] b);
    @(posedge clk);
    rst_n <= 1'b0;
    por_bo_reset <= por;
    boot_config_one <= b;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    por_bo_reset <= 1'b0;
  endtask
  task automatic sfr_w(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    sfr_wr <= 1'b1;
    sfr_addr <= a;
    sfr_wdata <= v;
    @(posedge clk);
    sfr_wr <= 1'b0;
    #1;
  endtask
  task automatic sfr_r(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    sfr_addr <= a;
    @(posedge clk);
    #1;
    v = sfr_rdata;
  endtask
  task automatic mem_r(input logic x, input logic [15:0] a, output logic t, output logic [7:0] v);
    @(posedge clk);
    code_rd <= !x;
    xdata_rd <= x;
    code_addr <= a;
    xdata_addr <= a;
    @(posedge clk);
    code_rd <= 1'b0;
    xdata_rd <= 1'b0;
    #1;
    t = x ? xdata_hit : code_hit;
    v = x ? xdata_rdata : code_rdata;
  endtask
  task automatic ptr(input acbc_ptr_op_e op, input logic [15:0] v);
    @(posedge clk);
    ptr_op <= op;
    ptr_load_val <= v;
    @(posedge clk);
    ptr_op <= ACBC_PTR_NONE;
    #1;
  endtask
  task automatic pins(input logic [3:0] v, input int n);
    @(posedge clk);
    keypad_pins_n <= v;
    keypad_enable <= 4'h2;
    repeat (n) @(posedge clk);
    #1;
  endtask
  initial begin
    do_reset(1'b1, 8'hFF);
    sfr_r(ACBC_AUX_ADDR, d);
    chk(16'(d), 16'h0000);
    mem_r(1'b1, 16'hFD01, h, d);
    chk(16'(h), 16'h0000);
    // Each oscillator code needs its own power-up, since config is only taken then.
    for (int i = 0; i < 5; i++) begin
      d = rnd();
      c = {i[0], ~i[0], d[5:3], osc[i]};
      do_reset(1'b1, c);
      repeat (6) @(posedge clk);
      #1;
      chk(16'(cfg), 16'(cfg_exp(c)));
      chk(16'({watchdog_reset_req, reset_pin_reset_req}), 16'({c[7], ~c[6]}));
      mem_r(1'b1, ACBC_CFG_ADDR, h, d);
      chk(16'({h, d}), 16'({1'b1, c}));
      @(posedge clk);
      boot_config_one <= ~c;
      repeat (3) @(posedge clk);
      #1;
      chk(16'(cfg), 16'(cfg_exp(c)));
    end
    foreach (rd_tab[i]) begin
      mem_r(1'b0, rd_tab[i][23:8], h, d);
      chk(16'({h, d}), 16'({1'b1, rd_tab[i][7:0]}));
    end
    e = 8'h00;
    repeat (8) begin
      d = rnd() & 8'h75 | 8'h04;
      e = aux_exp(e, d);
      sfr_w(ACBC_AUX_ADDR, d);
      chk(16'(pointer_select), 16'(d[0]));
      sfr_r(ACBC_AUX_ADDR, d);
      chk(16'(d), 16'(e));
    end
    for (int i = 0; i < 3; i++) begin
      d = 8'(i) << 5;
      e = {6'h00, d[6:5] == 2'h0, d[6:5] == 2'h1};
      sfr_w(ACBC_AUX_ADDR, d);
      chk(16'({brownout_reset_req, brownout_irq_req}), 16'(e[1:0]));
      chk(16'({brownout_off, brownout_irq_select}), 16'(d[6:5]));
    end
    p0 = {rnd(), rnd()};
    sfr_w(ACBC_AUX_ADDR, 8'h00);
    ptr(ACBC_PTR_LOAD16, p0);
    sfr_w(ACBC_AUX_ADDR, 8'h01);
    ptr(ACBC_PTR_LOAD16, 16'hFFFF);
    ptr(ACBC_PTR_INC, 16'h0000);
    chk(data_pointer, 16'h0000);
    sfr_w(ACBC_PTR_LO_ADDR, 8'h5A);
    sfr_r(ACBC_PTR_HI_ADDR, d);
    chk({d, data_pointer[7:0]}, 16'h005A);
    sfr_w(ACBC_AUX_ADDR, 8'h00);
    chk(data_pointer, p0);
    ptr(ACBC_PTR_WR_LO, 16'h3C3C);
    ptr(ACBC_PTR_WR_HI, 16'hC3C3);
    ptr(ACBC_PTR_INC, 16'h0000);
    chk(data_pointer, 16'hC33D);
    pins(4'hE, 6);
    chk(16'(keypad_flag), 16'h0000);
    pins(4'hD, 6);
    pins(4'hF, 4);
    chk(16'(keypad_flag), 16'h0001);
    sfr_w(ACBC_AUX_ADDR, 8'h00);
    chk(16'(keypad_flag), 16'h0000);
    sfr_w(ACBC_AUX_ADDR, 8'h10);
    sfr_w(ACBC_AUX_ADDR, 8'h08);
    chk(16'(soft_reset_bit), 16'h0001);
    do_reset(1'b0, boot_config_one);
    #1;
    chk(data_pointer, 16'h0000);
    sfr_r(ACBC_AUX_ADDR, d);
    chk(16'(d), 16'h0010);
    chk(16'(low_power_code_mem), 16'h0001);
    do_reset(1'b1, boot_config_one);
    sfr_r(ACBC_AUX_ADDR, d);
    chk(16'(d), 16'h0000);
    @(posedge clk);
    reset_input_pin <= 1'b1;
    brownout_raw <= 1'b0;
    watchdog_expired <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    chk(16'({reset_pin_reset_req, reset_input_level}), 16'h0001);
    chk(16'({brownout_reset_req, brownout_irq_req, watchdog_reset_req}), 16'h0000);
    stop_test();
  end
  initial begin
    #(40 * 5000);
    num_errors++;
    stop_test();
  end
endmodule
